/* File: rtl/vic_pkg.sv */
package vic_pkg;

	// ----------------------------------------------------------------
	// Register window
	// ----------------------------------------------------------------
	localparam logic [31:0] BASE_ADDR      = 32'hfffff000;
	localparam int          WINDOW_BITS    = 12;

	localparam logic [11:0] OFF_CFG_FIRST  = 12'h000;
	localparam logic [11:0] OFF_CFG_LAST   = 12'h07c;
	localparam logic [11:0] OFF_HDL_FIRST  = 12'h080;
	localparam logic [11:0] OFF_HDL_LAST   = 12'h0fc;
	localparam logic [11:0] OFF_NORM_VEC   = 12'h100;
	localparam logic [11:0] OFF_FAST_VEC   = 12'h104;
	localparam logic [11:0] OFF_CUR_SRC    = 12'h108;
	localparam logic [11:0] OFF_PENDING    = 12'h10c;
	localparam logic [11:0] OFF_MASK       = 12'h110;
	localparam logic [11:0] OFF_CORE_LINE  = 12'h114;
	localparam logic [11:0] OFF_RSVD_0     = 12'h118;
	localparam logic [11:0] OFF_RSVD_1     = 12'h11c;
	localparam logic [11:0] OFF_ENABLE     = 12'h120;
	localparam logic [11:0] OFF_DISABLE    = 12'h124;
	localparam logic [11:0] OFF_CLEAR      = 12'h128;
	localparam logic [11:0] OFF_SET        = 12'h12c;
	localparam logic [11:0] OFF_END_SVC    = 12'h130;
	localparam logic [11:0] OFF_SPURIOUS   = 12'h134;

	// ----------------------------------------------------------------
	// Field layout of a source configuration register
	// ----------------------------------------------------------------
	localparam int          PRI_LSB        = 0;
	localparam int          PRI_W          = 3;
	localparam int          TYPE_LSB       = 5;
	localparam int          TYPE_W         = 2;

	// Trigger type encodings for external sources.
	localparam logic [1:0]  TYPE_LOW_LEVEL = 2'h0;
	localparam logic [1:0]  TYPE_FALL_EDGE = 2'h1;
	localparam logic [1:0]  TYPE_HIGH_LVL  = 2'h2;
	localparam logic [1:0]  TYPE_RISE_EDGE = 2'h3;

	// Core line status bit positions.
	localparam int          CORE_FAST_BIT  = 0;
	localparam int          CORE_NORM_BIT  = 1;

	// ----------------------------------------------------------------
	// Sources and reset values
	// ----------------------------------------------------------------
	localparam int          NUM_SRC        = 32;
	localparam int          SRC_W          = 5;
	localparam int          NEST_DEPTH     = 8;
	localparam int          DEPTH_W        = 4;
	localparam logic [31:0] EXT_SRC_MASK   = 32'h3f000001;
	localparam logic [31:0] RESET_WORD     = 32'h00000000;
	localparam logic [2:0]  RESET_PRI      = 3'h0;
	localparam logic [1:0]  RESET_TYPE     = 2'h0;

endpackage

/* File: rtl/vic_regs.sv */
// Overview of operation
// RULE1 - Registers decode only inside the fixed base window; offsets relative to base.
// RULE2 - Thirty-two read/write source configuration words from offset zero, reset zero.
// RULE3 - Thirty-two read/write 32-bit handler address words, reset zero.
// RULE4 - Priority 0 lowest to 7 highest for sources 1-31; ignored for source 0.
// RULE5 - External trigger: 00 low level, 01 falling, 10 high level, 11 rising.
// RULE6 - Internal sources: low trigger bit picks level or edge, polarity fixed.
// RULE7 - Normal vector read returns handler address of current source 1-31.
// RULE8 - Normal vector read returns zero when no interrupt is current.
// RULE9 - Fast vector read returns handler address of source 0.
// RULE10 - Status register shows current serviced source number; resets to zero.
// RULE11 - Pending view: one bit per source, one means pending.
// RULE12 - At reset external pending bits follow line levels, others cleared; the code leaves internal bits following their lines too (level, active high).
// RULE13 - Mask view and core line status view, read-only, reset zero.
// RULE14 - Five write-only command words: enable, disable, clear, set, end of service.
// RULE15 - Ones written enable or disable sources; zeros no effect; shown in mask.
// RULE16 - Any write to end of service completes the current interrupt.
// RULE17 - Normal vector read drops request line and clears edge current source.
// RULE18 - Priority in bits 2:0, trigger type in bits 6:5, rest zero.
// RULE19 - Command and reserved offsets read zero; reserved writes ignored.
`timescale 1ns/1ps
`default_nettype none

module vic_regs #(
	parameter logic [31:0] EXT_SOURCES = vic_pkg::EXT_SRC_MASK
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [31:0] regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdata,
	// Interrupt sources
	input  wire logic [31:0] srcIn,
	// Core request lines
	output logic             normalRequestLine,
	output logic             fastRequestLine
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0][2:0]  priorityLevel;
		logic [31:0][1:0]  triggerType;
		logic [31:0][31:0] handlerAddress;
		logic [31:0]       spuriousAddress;
		logic [31:0]       enableMask;
		logic [31:0]       edgeLatch;
		logic [31:0]       syncFirst;
		logic [31:0]       syncLevel;
		logic [31:0]       prevLevel;
		logic              curValid;
		logic [4:0]        curSource;
		logic [2:0]        curPriority;
		logic [7:0][4:0]   stackSource;
		logic [7:0][2:0]   stackPriority;
		logic [3:0]        stackDepth;
		logic [31:0]       readData;
		logic              normalLine;
		logic              fastLine;
	} vic_state_s;

	vic_state_s state_reg;
	vic_state_s state_next;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic        inWindow;
	logic [11:0] offset;
	logic [4:0]  wordIdx;
	logic        isCfg;
	logic        isHdl;

	// RULE1 base window decode
	assign inWindow = (regAddr[31:vic_pkg::WINDOW_BITS]
		== vic_pkg::BASE_ADDR[31:vic_pkg::WINDOW_BITS]);
	assign offset   = regAddr[11:0];
	assign wordIdx  = regAddr[6:2];
	assign isCfg    = inWindow && (offset <= vic_pkg::OFF_CFG_LAST);
	assign isHdl    = inWindow && (offset >= vic_pkg::OFF_HDL_FIRST)
		&& (offset <= vic_pkg::OFF_HDL_LAST);

	logic wrEnable;
	logic wrDisable;
	logic wrClear;
	logic wrSet;
	logic wrEndSvc;
	logic rdNormVec;

	assign wrEnable  = regWrite && inWindow && (offset == vic_pkg::OFF_ENABLE);
	assign wrDisable = regWrite && inWindow && (offset == vic_pkg::OFF_DISABLE);
	assign wrClear   = regWrite && inWindow && (offset == vic_pkg::OFF_CLEAR);
	assign wrSet     = regWrite && inWindow && (offset == vic_pkg::OFF_SET);
	// RULE16 any value ends service
	assign wrEndSvc  = regWrite && inWindow && (offset == vic_pkg::OFF_END_SVC);
	assign rdNormVec = regRead && inWindow && (offset == vic_pkg::OFF_NORM_VEC);

	// ----------------------------------------------------------------
	// Source conditioning
	// ----------------------------------------------------------------
	logic [31:0] isEdge;
	logic [31:0] activeLevel;
	logic [31:0] edgeSeen;
	logic [31:0] pending;

	generate
		for (genvar i = 0; i < vic_pkg::NUM_SRC; i++)
		begin : g_src
			logic ext;
			logic rise;
			logic fall;
			assign ext  = EXT_SOURCES[i];
			assign rise = state_reg.syncLevel[i] && !state_reg.prevLevel[i];
			assign fall = !state_reg.syncLevel[i] && state_reg.prevLevel[i];
			// RULE6 low bit picks edge or level
			assign isEdge[i] = state_reg.triggerType[i][0];
			// RULE5 external polarity select
			assign activeLevel[i] = (ext && !state_reg.triggerType[i][1])
				? !state_reg.syncLevel[i] : state_reg.syncLevel[i];
			assign edgeSeen[i] = (ext && !state_reg.triggerType[i][1]) ? fall : rise;
			// RULE11 pending bit per source
			assign pending[i] = isEdge[i] ? state_reg.edgeLatch[i] : activeLevel[i];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration over sources 1 to 31
	// ----------------------------------------------------------------
	logic       candValid;
	logic [4:0] candSource;
	logic [2:0] candPriority;

	always_comb
	begin
		candValid    = 1'b0;
		candSource   = 5'h00;
		candPriority = 3'h0;
		// RULE4 source 0 takes no part
		for (int i = vic_pkg::NUM_SRC - 1; i >= 1; i--)
		begin
			if (pending[i] && state_reg.enableMask[i]
				&& (!state_reg.curValid
				|| (state_reg.priorityLevel[i] > state_reg.curPriority))
				&& (!candValid || (state_reg.priorityLevel[i] >= candPriority)))
			begin
				candValid    = 1'b1;
				candSource   = 5'(i);
				candPriority = state_reg.priorityLevel[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	logic [31:0] readValue;

	always_comb
	begin
		readValue = 32'h00000000;
		if (isCfg)
		begin
			// RULE18 field placement
			readValue[vic_pkg::PRI_LSB +: vic_pkg::PRI_W] =
				state_reg.priorityLevel[wordIdx];
			readValue[vic_pkg::TYPE_LSB +: vic_pkg::TYPE_W] =
				state_reg.triggerType[wordIdx];
		end
		else if (isHdl)
		begin
			readValue = state_reg.handlerAddress[wordIdx];
		end
		else if (inWindow)
		begin
			unique case (offset)
				vic_pkg::OFF_NORM_VEC:
				begin
					// RULE7 vector of current source
					if (candValid)
						readValue = state_reg.handlerAddress[candSource];
					else if (state_reg.curValid)
						readValue = state_reg.handlerAddress[state_reg.curSource];
					// RULE8 zero when none current
					else
						readValue = 32'h00000000;
				end
				// RULE9 fast vector readout
				vic_pkg::OFF_FAST_VEC:
					readValue = state_reg.handlerAddress[0];
				// RULE10 current source number
				vic_pkg::OFF_CUR_SRC:
					readValue = {27'h0000000, state_reg.curSource};
				vic_pkg::OFF_PENDING:
					readValue = pending;
				// RULE13 mask and line views
				vic_pkg::OFF_MASK:
					readValue = state_reg.enableMask;
				vic_pkg::OFF_CORE_LINE:
				begin
					readValue[vic_pkg::CORE_NORM_BIT] = state_reg.normalLine;
					readValue[vic_pkg::CORE_FAST_BIT] = state_reg.fastLine;
				end
				vic_pkg::OFF_SPURIOUS:
					readValue = state_reg.spuriousAddress;
				// RULE19 commands and reserved read zero
				default:
					readValue = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;

		state_next.syncFirst = srcIn;
		state_next.syncLevel = state_reg.syncFirst;
		state_next.prevLevel = state_reg.syncLevel;

		// RULE2 configuration write
		if (regWrite && isCfg)
		begin
			state_next.priorityLevel[wordIdx] =
				regWdata[vic_pkg::PRI_LSB +: vic_pkg::PRI_W];
			state_next.triggerType[wordIdx] =
				regWdata[vic_pkg::TYPE_LSB +: vic_pkg::TYPE_W];
		end
		// RULE3 handler address write
		if (regWrite && isHdl)
			state_next.handlerAddress[wordIdx] = regWdata;
		if (regWrite && inWindow && (offset == vic_pkg::OFF_SPURIOUS))
			state_next.spuriousAddress = regWdata;

		// RULE15 ones enable or disable
		if (wrEnable)
			state_next.enableMask = state_reg.enableMask | regWdata;
		if (wrDisable)
			state_next.enableMask = state_reg.enableMask & ~regWdata;

		// Edge latches; a new edge beats a same-cycle clear.
		for (int i = 0; i < vic_pkg::NUM_SRC; i++)
		begin
			logic setEv;
			logic clrEv;
			setEv = edgeSeen[i] || (wrSet && regWdata[i]);
			// RULE17 vector read clears edge source
			clrEv = (wrClear && regWdata[i])
				|| (rdNormVec && candValid && (candSource == 5'(i)));
			if (!isEdge[i])
				state_next.edgeLatch[i] = 1'b0;
			else
				state_next.edgeLatch[i] = setEv || (state_reg.edgeLatch[i] && !clrEv);
		end

		// RULE17 take the new current source
		if (rdNormVec && candValid)
		begin
			if (state_reg.curValid
				&& (state_reg.stackDepth < 4'(vic_pkg::NEST_DEPTH)))
			begin
				state_next.stackSource[state_reg.stackDepth[2:0]] =
					state_reg.curSource;
				state_next.stackPriority[state_reg.stackDepth[2:0]] =
					state_reg.curPriority;
				state_next.stackDepth = state_reg.stackDepth + 4'h1;
			end
			state_next.curValid    = 1'b1;
			state_next.curSource   = candSource;
			state_next.curPriority = candPriority;
		end
		// RULE16 restore preceding level
		else if (wrEndSvc)
		begin
			if (state_reg.stackDepth != 4'h0)
			begin
				state_next.curSource   =
					state_reg.stackSource[state_reg.stackDepth[2:0] - 3'h1];
				state_next.curPriority =
					state_reg.stackPriority[state_reg.stackDepth[2:0] - 3'h1];
				state_next.stackDepth  = state_reg.stackDepth - 4'h1;
			end
			else
			begin
				state_next.curValid    = 1'b0;
				state_next.curSource   = 5'h00;
				state_next.curPriority = 3'h0;
			end
		end

		// RULE17 line drops on vector read
		state_next.normalLine = candValid && !rdNormVec && !wrEndSvc;
		state_next.fastLine   = pending[0] && state_reg.enableMask[0];

		// RULE19 data only in the cycle after a read
		state_next.readData = regRead ? readValue : 32'h00000000;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			// RULE12 edge latches cleared, levels follow lines
			state_reg           <= '0;
			state_reg.syncFirst <= srcIn;
			state_reg.syncLevel <= state_reg.syncFirst;
			state_reg.prevLevel <= state_reg.syncLevel;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regRdata          = state_reg.readData;
	assign normalRequestLine = state_reg.normalLine;
	assign fastRequestLine   = state_reg.fastLine;

endmodule

`default_nettype wire

/* File: bench/vic_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module vic_regs_chk (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [31:0] regRdata,
	// Sources and request lines
	input wire logic [31:0] srcIn,
	input wire logic        normalRequestLine,
	input wire logic        fastRequestLine
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic inWin = regAddr[31:12] == 20'hfffff;
	wire logic [11:0] off = regAddr[11:0];
	property p_idle;
		!regRead |=> regRdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("read data not zero outside a read");
	property p_outside;
		regRead && !inWin |=> regRdata == 32'h0;
	endproperty
	a_outside: assert property (p_outside)
		else $error("read outside window not zero");
	property p_command;
		regRead && inWin && off inside {[12'h118:12'h130]} |=> regRdata == 32'h0;
	endproperty
	a_command: assert property (p_command)
		else $error("command or reserved read not zero");
	property p_fields;
		regRead && inWin && off[11:7] == 5'h0 |=> regRdata[31:7] == 25'h0 && regRdata[4:3] == 2'h0;
	endproperty
	a_fields: assert property (p_fields)
		else $error("unused configuration bits not zero");
	property p_status;
		regRead && inWin && off == 12'h108 |=> regRdata[31:5] == 27'h0;
	endproperty
	a_status: assert property (p_status)
		else $error("status upper bits not zero");
	property p_core;
		regRead && inWin && off == 12'h114
			|=> regRdata == {30'h0, $past(normalRequestLine), $past(fastRequestLine)};
	endproperty
	a_core: assert property (p_core)
		else $error("core line status mismatch");
	property p_vector;
		regRead && inWin && off == 12'h100 && normalRequestLine |=> !normalRequestLine;
	endproperty
	a_vector: assert property (p_vector)
		else $error("normal line kept after vector read");
	property p_endsvc;
		regWrite && inWin && off == 12'h130 |=> !normalRequestLine;
	endproperty
	a_endsvc: assert property (p_endsvc)
		else $error("normal line kept after end of service");
	property p_reset;
		$rose(rst_n) |-> regRdata == 32'h0 && !normalRequestLine && !fastRequestLine;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not clear after reset");
endmodule
bind vic_regs vic_regs_chk u_vic_regs_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
	.regRdata(regRdata), .srcIn(srcIn), .normalRequestLine(normalRequestLine),
	.fastRequestLine(fastRequestLine));
`default_nettype wire

/* File: bench/vic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Request lines from the controller
	input  wire logic normalRequestLine,
	input  wire logic fastRequestLine,
	// Number of request assertions taken
	output var int    normalCount,
	output var int    fastCount
);
	logic normPrev;
	logic fastPrev;
	// The core takes each rising request line as one interrupt entry.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			normalCount <= 0;
			fastCount <= 0;
		end
		else
		begin
			normalCount <= normalCount + int'(normalRequestLine && !normPrev);
			fastCount <= fastCount + int'(fastRequestLine && !fastPrev);
		end
		normPrev <= rst_n && normalRequestLine;
		fastPrev <= rst_n && fastRequestLine;
	end
endmodule
`default_nettype wire

/* File: bench/test_vectored_irq_controller_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_vectored_irq_controller_regs;
	localparam logic [31:0] B = vic_pkg::BASE_ADDR;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] regAddr = 32'h0;
	logic [31:0] regWdata = 32'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [31:0] srcIn = 32'h3e000001;
	logic [31:0] regRdata;
	logic        normalRequestLine;
	logic        fastRequestLine;
	int          normalCount;
	int          fastCount;
	int          errors = 0;
	int          tests_run = 0;
	int          k;
	vic_regs u_vic_regs (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.srcIn(srcIn), .normalRequestLine(normalRequestLine), .fastRequestLine(fastRequestLine));
	vic_core_model u_vic_core_model (.ref_clk(ref_clk), .rst_n(rst_n),
		.normalRequestLine(normalRequestLine), .fastRequestLine(fastRequestLine),
		.normalCount(normalCount), .fastCount(fastCount));
	task end_sim;
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWrite <= w;
		regRead <= !w;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		#1;
	endtask
	task wr(input logic [11:0] o, input logic [31:0] d);
		bus(1'b1, B | 32'(o), d);
	endtask
	task rd(input logic [11:0] o, input logic [31:0] e);
		bus(1'b0, B | 32'(o), 32'h0);
		check($sformatf("offset %h", o), regRdata, e);
	endtask
	task waitHigh(input logic f);
		int n;
		n = 0;
		while ((f ? fastRequestLine : normalRequestLine) !== 1'b1 && n < 20)
		begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		check("request line", f ? fastRequestLine : normalRequestLine, 32'h1);
	endtask
	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		end_sim;
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (k = 0; k < 78; k++)
			rd(12'(k * 4), (k == 67) ? 32'h01000000 : 32'h0);
		for (k = 0; k < 32; k++)
			wr(12'(128 + k * 4), 32'ha5000000 | 32'(k));
		for (k = 0; k < 32; k++)
			rd(12'(128 + k * 4), 32'ha5000000 | 32'(k));
		wr(12'h07c, 32'hffffffff);
		wr(12'h118, 32'hffffffff);
		bus(1'b1, 32'h0000f07c, 32'h0);
		rd(12'h07c, 32'h00000067);
		rd(12'h118, 32'h0);
		wr(12'h004, 32'h00000022);
		wr(12'h12c, 32'h00000006);
		rd(12'h10c, 32'h01000002);
		wr(12'h128, 32'h00000002);
		rd(12'h10c, 32'h01000000);
		wr(12'h120, 32'h0000002e);
		wr(12'h124, 32'h00000004);
		wr(12'h120, 32'h0);
		rd(12'h110, 32'h0000002a);
		wr(12'h014, 32'h00000063);
		@(posedge ref_clk);
		srcIn[5] <= 1'b1;
		waitHigh(1'b0);
		rd(12'h10c, 32'h01000020);
		rd(12'h100, 32'ha5000005);
		check("normal line", normalRequestLine, 32'h0);
		rd(12'h108, 32'h00000005);
		rd(12'h10c, 32'h01000000);
		wr(12'h130, 32'h0);
		rd(12'h108, 32'h0);
		rd(12'h100, 32'h0);
		wr(12'h00c, 32'h00000066);
		wr(12'h12c, 32'h0000000a);
		waitHigh(1'b0);
		rd(12'h100, 32'ha5000003);
		wr(12'h130, 32'h0);
		waitHigh(1'b0);
		rd(12'h100, 32'ha5000001);
		wr(12'h130, 32'h0);
		for (k = 0; k < 4; k++)
		begin
			wr(12'h128, 32'h1);
			wr(12'h000, 32'(k) << 5);
			srcIn[0] <= 1'b0;
			repeat (5) @(posedge ref_clk);
			rd(12'h10c, 32'h01000000 | 32'(k < 2));
			srcIn[0] <= 1'b1;
			repeat (5) @(posedge ref_clk);
			rd(12'h10c, 32'h01000000 | 32'(k != 0));
		end
		wr(12'h120, 32'h1);
		waitHigh(1'b1);
		rd(12'h104, 32'ha5000000);
		rd(12'h114, 32'h1);
		check("fast line", fastRequestLine, 32'h1);
		check("normal entries", normalCount, 32'h3);
		check("fast entries", fastCount, 32'h1);
		end_sim;
	end
endmodule
`default_nettype wire
